/* rtl/ufn_pkg.sv */
// constants shared by the frame number and low-speed threshold logic
package ufn_pkg;

  // field widths
  localparam int unsigned FRAME_COUNT_W = 16;      // frame counter width
  localparam int unsigned LST_W         = 11;      // low-speed threshold width
  localparam int unsigned BITS_LEFT_W   = 14;      // bit times left in frame
  localparam int unsigned DATA_W        = 32;      // command data width
  localparam int unsigned CMD_W         = 8;       // command code width
  localparam int unsigned DIV_W         = 5;       // bit-time divider width

  // command codes
  localparam logic [CMD_W-1:0] CMD_RD_FRAME_COUNT = 8'h0f;  // read frame count
  localparam logic [CMD_W-1:0] CMD_RD_LST         = 8'h11;  // read threshold
  localparam logic [CMD_W-1:0] CMD_WR_LST         = 8'h91;  // write threshold
  localparam int unsigned      CMD_WR_BIT         = 7;      // set on write codes

  // reset and default values
  localparam logic [FRAME_COUNT_W-1:0] FRAME_COUNT_RESET    = 16'h0000;
  localparam logic [FRAME_COUNT_W-1:0] FRAME_COUNT_MAX      = 16'hffff;
  localparam logic [FRAME_COUNT_W-1:0] FRAME_COUNT_STEP     = 16'h0001;
  localparam logic [LST_W-1:0]         LST_RESET            = 11'h628;   // 1576
  localparam logic [BITS_LEFT_W-1:0]   FRAME_PERIOD_DEFAULT = 14'h2edf;  // 11999
  localparam logic [BITS_LEFT_W-1:0]   BITS_LEFT_STEP       = 14'h0001;
  localparam logic [BITS_LEFT_W-1:0]   BITS_LEFT_ZERO       = 14'h0000;
  localparam logic [DATA_W-1:0]        DATA_ZERO            = 32'h0000_0000;

  // bit-time rate derived from the system clock
  localparam int unsigned CLK_PERIOD_PS = 4000;    // 250 mhz system clock
  localparam int unsigned BIT_TIME_PS   = 83333;   // 12 mbit/s bit time
  localparam int unsigned BIT_DIV       = BIT_TIME_PS / CLK_PERIOD_PS;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  localparam logic [DIV_W-1:0] DIV_STEP = 5'h01;

endpackage : ufn_pkg

/* rtl/ufn_timing_if.sv */
// timing signals between frame control and the bit-time counter
`timescale 1ns/1ps
interface ufn_timing_if;
  logic                               run;           // counter runs while operational
  logic                               enter;         // one-cycle operational entry
  logic [ufn_pkg::BITS_LEFT_W-1:0]    frame_period;  // reload value
  logic                               bit_tick;      // one-cycle bit-time enable
  logic                               reload;        // one-cycle reload pulse
  logic [ufn_pkg::BITS_LEFT_W-1:0]    bits_left;     // bit times left in frame

  // bit-time counter side
  modport timer (input run, input enter, input frame_period,
                 output bit_tick, output reload, output bits_left);
  // frame control side
  modport ctrl  (output run, output enter, output frame_period,
                 input bit_tick, input reload, input bits_left);
endinterface : ufn_timing_if

/* rtl/ufn_bit_timer.sv */
// bit-time divider and bit-times-left down counter with frame reload
`timescale 1ns/1ps
module ufn_bit_timer (
  input  wire logic   clk_sys_i,  // system clock
  input  wire logic   rst_i,      // synchronous reset, active high
  ufn_timing_if.timer tif         // timing link to frame control
);

  logic [ufn_pkg::DIV_W-1:0]       div_ff;        // bit-time divider
  logic [ufn_pkg::DIV_W-1:0]       nxt_div;
  logic                            tick_ff;       // bit-time enable pulse
  logic                            nxt_tick;
  logic [ufn_pkg::BITS_LEFT_W-1:0] left_ff;       // bit times left
  logic [ufn_pkg::BITS_LEFT_W-1:0] nxt_left;
  logic                            reload_ff;     // reload pulse
  logic                            nxt_reload;
  logic [ufn_pkg::BITS_LEFT_W-1:0] period;        // effective reload value

  // a zero period would stall the frame, so fall back to the default
  assign period = (tif.frame_period == ufn_pkg::BITS_LEFT_ZERO) ?
                  ufn_pkg::FRAME_PERIOD_DEFAULT : tif.frame_period;

  // next values of divider, counter and reload pulse
  always_comb begin
    nxt_div    = div_ff;
    nxt_tick   = 1'b0;
    nxt_left   = left_ff;
    nxt_reload = 1'b0;
    // divider free-runs, pulse on the last count
    if (div_ff == ufn_pkg::DIV_LAST) begin
      nxt_div  = ufn_pkg::DIV_ZERO;
      nxt_tick = 1'b1;
    end else begin
      nxt_div  = div_ff + ufn_pkg::DIV_STEP;
    end
    if (tif.enter) begin
      // operational entry loads the frame and counts as a reload
      nxt_left   = period;
      nxt_reload = 1'b1;
    end else if (tif.run && tick_ff) begin
      if (left_ff == ufn_pkg::BITS_LEFT_ZERO) begin
        // reload at the bit-time boundary after reaching zero
        nxt_left   = period;
        nxt_reload = 1'b1;
      end else begin
        // one bit time gone
        nxt_left = left_ff - ufn_pkg::BITS_LEFT_STEP;
      end
    end
  end

  // register the timer state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_ff    <= ufn_pkg::DIV_ZERO;
      tick_ff   <= 1'b0;
      left_ff   <= ufn_pkg::BITS_LEFT_ZERO;
      reload_ff <= 1'b0;
    end else begin
      div_ff    <= nxt_div;
      tick_ff   <= nxt_tick;
      left_ff   <= nxt_left;
      reload_ff <= nxt_reload;
    end
  end

  assign tif.bit_tick  = tick_ff;
  assign tif.reload    = reload_ff;
  assign tif.bits_left = left_ff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // counter steps down by one on a bit time
  property p_left_dec;
    (tif.run && tick_ff && !tif.enter && left_ff != ufn_pkg::BITS_LEFT_ZERO)
      |=> (left_ff == $past(left_ff) - ufn_pkg::BITS_LEFT_STEP) && !reload_ff;
  endproperty
  a_left_dec : assert property (p_left_dec)
    else $error("bits left did not decrement");

  // zero reloads the period with a pulse
  property p_left_reload;
    (tif.run && tick_ff && left_ff == ufn_pkg::BITS_LEFT_ZERO)
      |=> reload_ff && (left_ff == $past(period));
  endproperty
  a_left_reload : assert property (p_left_reload)
    else $error("bits left did not reload at zero");

endmodule // ufn_bit_timer

/* rtl/ufn_frame_timer.sv */
// frame number counter, low-speed threshold register and command decode
`timescale 1ns/1ps
// Overview of operation
// - frame count is 16 bits, upper zero
// - frame count increments on every frame reload
// - frame count wraps from maximum to zero
// - operational entry increments frame count automatically
// - each increment raises the frame start flag
// - frame count read-only via code 0f
// - threshold is 11 bits, upper bits zero
// - start low-speed only if left >= threshold
// - check commits eight-byte low-speed packet
// - threshold resets to 1576
// - threshold read code 11, write 91
// - threshold stays fixed while scheduling
// - bits left decrements, reloads after zero
// - frame period defaults to 11999
module ufn_frame_timer (
  input  wire logic                              clk_sys_i,           // system clock
  input  wire logic                              rst_i,               // sync reset, high
  input  wire logic                              operational_i,       // operational state
  input  wire logic [ufn_pkg::BITS_LEFT_W-1:0]   frame_period_i,      // frame period
  input  wire logic                              cmd_valid_i,         // command strobe
  input  wire logic [ufn_pkg::CMD_W-1:0]         cmd_code_i,          // command code
  input  wire logic [ufn_pkg::DATA_W-1:0]        cmd_wdata_i,         // write data
  input  wire logic                              ls_request_i,        // low-speed ask
  output logic      [ufn_pkg::DATA_W-1:0]        rd_data_o,           // read data
  output logic                                   rd_valid_o,          // read data valid
  output logic                                   frame_start_flag_o,  // frame start set
  output logic                                   ls_start_o,          // low-speed go
  output logic                                   ls_refuse_o,         // low-speed no
  output logic      [ufn_pkg::BITS_LEFT_W-1:0]   frame_bits_left_o    // bits left
);

  // read codes have the write bit clear
  function automatic logic is_read_code(input logic [ufn_pkg::CMD_W-1:0] code);
    return !code[ufn_pkg::CMD_WR_BIT];
  endfunction

  ufn_timing_if tif ();  // link to the bit-time counter

  logic [ufn_pkg::FRAME_COUNT_W-1:0] frame_count_ff;   // frame count
  logic [ufn_pkg::FRAME_COUNT_W-1:0] nxt_frame_count;
  logic [ufn_pkg::LST_W-1:0]         lst_ff;           // low-speed threshold
  logic [ufn_pkg::LST_W-1:0]         nxt_lst;
  logic                              op_ff;            // previous operational level
  logic [ufn_pkg::DATA_W-1:0]        rd_data_ff;       // read data
  logic [ufn_pkg::DATA_W-1:0]        nxt_rd_data;
  logic                              rd_valid_ff;      // read valid pulse
  logic                              nxt_rd_valid;
  logic                              sof_ff;           // frame start pulse
  logic                              ls_start_ff;      // low-speed grant pulse
  logic                              nxt_ls_start;
  logic                              ls_refuse_ff;     // low-speed refusal pulse
  logic                              nxt_ls_refuse;
  logic                              lst_locked;       // threshold frozen
  logic                              ls_fits;          // enough bits left

  // operational entry is the rising edge of the state level
  assign tif.enter        = operational_i && !op_ff;
  assign tif.run          = operational_i;
  assign tif.frame_period = frame_period_i;

  // bit-time counter and reload source
  ufn_bit_timer u_bit_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tif       (tif)
  );

  // threshold is frozen while transfers are scheduled
  assign lst_locked = operational_i || op_ff;
  // eight-byte low-speed packet is committed only if it fits
  assign ls_fits = tif.bits_left >= ufn_pkg::BITS_LEFT_W'(lst_ff);

  // frame count, threshold and command answers
  always_comb begin
    nxt_frame_count = frame_count_ff;
    nxt_lst         = lst_ff;
    nxt_rd_data     = ufn_pkg::DATA_ZERO;
    nxt_rd_valid    = 1'b0;
    nxt_ls_start    = 1'b0;
    nxt_ls_refuse   = 1'b0;
    // count frames on each reload, wrapping naturally at the top
    if (tif.reload) begin
      nxt_frame_count = frame_count_ff + ufn_pkg::FRAME_COUNT_STEP;
    end
    if (cmd_valid_i) begin
      if (is_read_code(cmd_code_i)) begin
        nxt_rd_valid = 1'b1;
        case (cmd_code_i)
          // frame count read, upper half zero
          ufn_pkg::CMD_RD_FRAME_COUNT: begin
            nxt_rd_data = ufn_pkg::DATA_W'(frame_count_ff);
          end
          // threshold read, upper bits zero
          ufn_pkg::CMD_RD_LST: begin
            nxt_rd_data = ufn_pkg::DATA_W'(lst_ff);
          end
          // unmapped read answers zero
          default: begin
            nxt_rd_data = ufn_pkg::DATA_ZERO;
          end
        endcase
      end else if (cmd_code_i == ufn_pkg::CMD_WR_LST && !lst_locked) begin
        // threshold write, reserved bits dropped
        nxt_lst = cmd_wdata_i[ufn_pkg::LST_W-1:0];
      end
    end
    // low-speed start decision
    if (ls_request_i) begin
      nxt_ls_start  = ls_fits;
      nxt_ls_refuse = !ls_fits;
    end
  end

  // register frame count, threshold and answers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_count_ff <= ufn_pkg::FRAME_COUNT_RESET;
      lst_ff         <= ufn_pkg::LST_RESET;
      op_ff          <= 1'b0;
      rd_data_ff     <= ufn_pkg::DATA_ZERO;
      rd_valid_ff    <= 1'b0;
      sof_ff         <= 1'b0;
      ls_start_ff    <= 1'b0;
      ls_refuse_ff   <= 1'b0;
    end else begin
      frame_count_ff <= nxt_frame_count;
      lst_ff         <= nxt_lst;
      op_ff          <= operational_i;
      rd_data_ff     <= nxt_rd_data;
      rd_valid_ff    <= nxt_rd_valid;
      sof_ff         <= tif.reload;
      ls_start_ff    <= nxt_ls_start;
      ls_refuse_ff   <= nxt_ls_refuse;
    end
  end

  assign rd_data_o          = rd_data_ff;
  assign rd_valid_o         = rd_valid_ff;
  assign frame_start_flag_o = sof_ff;
  assign ls_start_o         = ls_start_ff;
  assign ls_refuse_o        = ls_refuse_ff;
  assign frame_bits_left_o  = tif.bits_left;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // entry leads to a reload and then a frame start
  sequence s_reload_then_sof;
    tif.reload ##1 sof_ff;
  endsequence

  property p_entry_inc;
    tif.enter |=> s_reload_then_sof;
  endproperty
  a_entry_inc : assert property (p_entry_inc)
    else $error("operational entry did not start a frame");

  property p_count_inc;
    tif.reload && frame_count_ff != ufn_pkg::FRAME_COUNT_MAX
      |=> frame_count_ff == $past(frame_count_ff) + ufn_pkg::FRAME_COUNT_STEP;
  endproperty
  a_count_inc : assert property (p_count_inc)
    else $error("frame count did not increment on reload");

  property p_count_wrap;
    tif.reload && frame_count_ff == ufn_pkg::FRAME_COUNT_MAX
      |=> frame_count_ff == ufn_pkg::FRAME_COUNT_RESET;
  endproperty
  a_count_wrap : assert property (p_count_wrap)
    else $error("frame count did not wrap to zero");

  property p_count_hold;
    !tif.reload |=> $stable(frame_count_ff);
  endproperty
  a_count_hold : assert property (p_count_hold)
    else $error("frame count moved without reload");

  property p_sof_cause;
    sof_ff |-> $past(tif.reload) && frame_count_ff != $past(frame_count_ff);
  endproperty
  a_sof_cause : assert property (p_sof_cause)
    else $error("frame start flag without increment");

  property p_read_count;
    cmd_valid_i && cmd_code_i == ufn_pkg::CMD_RD_FRAME_COUNT
      |=> rd_valid_ff && rd_data_ff == ufn_pkg::DATA_W'($past(frame_count_ff));
  endproperty
  a_read_count : assert property (p_read_count)
    else $error("frame count read returned wrong data");

  property p_read_lst;
    cmd_valid_i && cmd_code_i == ufn_pkg::CMD_RD_LST
      |=> rd_valid_ff && rd_data_ff == ufn_pkg::DATA_W'($past(lst_ff));
  endproperty
  a_read_lst : assert property (p_read_lst)
    else $error("threshold read returned wrong data");

  property p_write_lst;
    cmd_valid_i && cmd_code_i == ufn_pkg::CMD_WR_LST && !lst_locked
      |=> lst_ff == $past(cmd_wdata_i[ufn_pkg::LST_W-1:0]);
  endproperty
  a_write_lst : assert property (p_write_lst)
    else $error("threshold write not stored");

  property p_lst_frozen;
    lst_locked |=> $stable(lst_ff);
  endproperty
  a_lst_frozen : assert property (p_lst_frozen)
    else $error("threshold changed while operational");

  property p_ls_decide;
    ls_request_i |=> (ls_start_ff == ($past(tif.bits_left) >=
      ufn_pkg::BITS_LEFT_W'($past(lst_ff)))) && (ls_refuse_ff == !ls_start_ff);
  endproperty
  a_ls_decide : assert property (p_ls_decide)
    else $error("low-speed start decision wrong");

endmodule // ufn_frame_timer

/* verification/ufn_host_model.sv */
// host driver model that issues command codes to the frame timer
`timescale 1ns/1ps
module ufn_host_model (
  input  wire logic                        clk_sys_i,    // system clock
  input  wire logic [ufn_pkg::DATA_W-1:0]  rd_data_i,    // read data
  input  wire logic                        rd_valid_i,   // read data valid
  output logic                             cmd_valid_o,  // command strobe
  output logic      [ufn_pkg::CMD_W-1:0]   cmd_code_o,   // command code
  output logic      [ufn_pkg::DATA_W-1:0]  cmd_wdata_o   // write data
);
  logic [ufn_pkg::DATA_W-1:0] ext_frame;  // software 32-bit frame number

  // idle strobe from time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 32'h0000_0000;
    ext_frame   = 32'h0000_0000;
  end

  // one command: strobe for a single cycle, answer taken after the taking edge
  task automatic issue(input logic [7:0] code, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic vld);
    @(posedge clk_sys_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o  = code;
    cmd_wdata_o = wdata;
    @(posedge clk_sys_i);
    #1;
    cmd_valid_o = 1'b0;
    // code and data are not held after the command: show the inverse
    cmd_code_o  = ~cmd_code_o;
    cmd_wdata_o = ~cmd_wdata_o;
    rdata = rd_data_i;
    vld   = rd_valid_i;
  endtask

  // read the 16-bit count and extend it in software to 32 bits
  task automatic read_frame_ext(output logic [31:0] frame32, output logic vld);
    logic [31:0] raw;
    issue(ufn_pkg::CMD_RD_FRAME_COUNT, 32'h0000_0000, raw, vld);
    if (raw[15:0] < ext_frame[15:0]) begin
      ext_frame[31:16] = ext_frame[31:16] + 16'h0001;
    end
    ext_frame[15:0] = raw[15:0];
    frame32 = ext_frame;
  endtask

  // threshold in bit times: packet length plus transmit and set-up overhead
  function automatic logic [10:0] calc_threshold(input int unsigned pkt_bits,
                                                 input int unsigned overhead);
    return 11'(pkt_bits + overhead);
  endfunction

  // threshold write; one caller issues it during the scheduling period, where it is ignored
  task automatic set_threshold(input logic [31:0] wdata);
    logic [31:0] unused_rd;
    logic        unused_vld;
    issue(ufn_pkg::CMD_WR_LST, wdata, unused_rd, unused_vld);
  endtask
endmodule // ufn_host_model

/* verification/ufn_frame_timer_tb.sv */
// self-checking testbench for the frame number and low-speed threshold logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ufn_frame_timer_tb;
  logic        clk_sys_i = 1'b0;      // system clock
  logic        rst_i = 1'b1;          // synchronous reset
  logic        operational_i = 1'b0;  // operational state
  logic [13:0] frame_period_i = 14'h0000;  // 0 selects default period
  logic        cmd_valid_i;           // from host model
  logic [7:0]  cmd_code_i;            // from host model
  logic [31:0] cmd_wdata_i;           // from host model
  logic        ls_request_i = 1'b0;   // low-speed ask
  logic [31:0] rd_data_o;             // read data
  logic        rd_valid_o;            // read valid
  logic        frame_start_flag_o;    // frame start pulse
  logic        ls_start_o;            // low-speed go
  logic        ls_refuse_o;           // low-speed no
  logic [13:0] frame_bits_left_o;     // bits left
  int          num_errors = 0;        // mismatches
  int          checked = 0;           // comparisons
  int          cycles = 0;            // timeout counter
  logic [31:0] fr;                    // frame number read back
  logic        fv;                    // read valid seen

  // 250 mhz clock
  always #2 clk_sys_i = ~clk_sys_i;

  ufn_frame_timer ufn_frame_timer_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .operational_i(operational_i),
    .frame_period_i(frame_period_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_wdata_i(cmd_wdata_i), .ls_request_i(ls_request_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .frame_start_flag_o(frame_start_flag_o),
    .ls_start_o(ls_start_o), .ls_refuse_o(ls_refuse_o),
    .frame_bits_left_o(frame_bits_left_o));

  ufn_host_model ufn_host_model_i (
    .clk_sys_i(clk_sys_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));

  // verdict and end of run
  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // read a code and compare the answer word
  task automatic rd(input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    ufn_host_model_i.issue(code, 32'h0000_0000, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rd_data", exp, d)
  endtask

  // bounded wait for the frame start pulse or a given bits-left value
  task automatic wait_for(input bit want_flag, input logic [13:0] left, input int limit);
    bit hit;
    hit = 1'b0;
    for (int i = 0; i < limit && !hit; i++) begin
      @(posedge clk_sys_i);
      #1;
      hit = want_flag ? (frame_start_flag_o === 1'b1) : (frame_bits_left_o === left);
    end
    `CHK("wait", 1'b1, hit)
  endtask

  // one low-speed ask against the current bits-left value
  task automatic ls_ask(input logic exp_start);
    ls_request_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    ls_request_i = 1'b0;
    `CHK("ls_start", exp_start, ls_start_o)
    `CHK("ls_refuse", ~exp_start, ls_refuse_o)
  endtask

  // hang guard: the full sequence needs under 500 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    `CHK("left_reset", 14'h0000, frame_bits_left_o)
    rd(8'h0f, 32'h0000_0000);
    rd(8'h11, 32'h0000_0628);
    rd(8'h12, 32'h0000_0000);
    ufn_host_model_i.issue(8'h8f, 32'hffff_ffff, fr, fv);
    `CHK("wr_answer", 1'b0, fv)
    rd(8'h0f, 32'h0000_0000);
    ufn_host_model_i.set_threshold(32'hffff_ffff);
    rd(8'h11, 32'h0000_07ff);
    repeat (40) @(posedge clk_sys_i);
    rd(8'h0f, 32'h0000_0000);
    ufn_host_model_i.set_threshold({21'h0, ufn_host_model_i.calc_threshold(2, 1)});
    rd(8'h11, 32'h0000_0003);
    // entry with the default period
    operational_i = 1'b1;
    wait_for(1'b1, 14'h0000, 4);
    `CHK("left_dflt", 1'b1, frame_bits_left_o inside {14'd11999, 14'd11998})
    ufn_host_model_i.read_frame_ext(fr, fv);
    `CHK("count_entry", 32'h0000_0001, fr)
    ufn_host_model_i.set_threshold(32'h0000_0005);
    rd(8'h11, 32'h0000_0003);
    operational_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    frame_period_i = 14'd5;
    operational_i = 1'b1;
    wait_for(1'b1, 14'h0000, 4);
    `CHK("left_entry", 1'b1, frame_bits_left_o inside {14'd5, 14'd4})
    wait_for(1'b0, 14'd4, 25);
    wait_for(1'b0, 14'd3, 25);
    ls_ask(1'b1);
    wait_for(1'b0, 14'd2, 25);
    ls_ask(1'b0);
    repeat (3) wait_for(1'b1, 14'h0000, 130);
    `CHK("left_reload", 14'd5, frame_bits_left_o)
    ufn_host_model_i.read_frame_ext(fr, fv);
    `CHK("count_frames", 32'h0000_0005, fr)
    operational_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    tally_and_finish();
  end
endmodule // ufn_frame_timer_tb
